// ==== common/clcd_glyph_if.sv ====
// lookup path between the scan logic and the glyph rom
`timescale 1ns/1ns
interface clcd_glyph_if;
	logic [7:0] code;
	logic [3:0] row;
	logic [4:0] dots;
	modport rom (input code, input row, output dots);
	modport user (output code, output row, input dots);
endinterface : clcd_glyph_if

// ==== common/clcd_pkg.sv ====
// constants and types shared by the character display address and glyph memory block
package clcd_pkg;
	// =====================================================================
	// memory organisation
	localparam int PTR_W = 7;
	localparam int TEXT_DEPTH = 80;
	localparam int GLYPH_DEPTH = 64;
	localparam int RING_LEN = 40;
	localparam int LINE_LEN = 20;
	localparam logic [6:0] PTR_RESET = 7'h00;
	localparam logic [6:0] RING0_BASE = 7'h00;
	localparam logic [6:0] RING0_LAST = 7'h27;
	localparam logic [6:0] RING1_BASE = 7'h40;
	localparam logic [6:0] RING1_LAST = 7'h67;
	localparam logic [6:0] RING1_INDEX = 7'h28;
	localparam logic [6:0] LOWER_HALF_OFFSET = 7'h14;
	localparam logic [6:0] RING_LEN_7 = 7'h28;
	// =====================================================================
	// command and readback bit positions
	localparam int CMD_TEXT_BIT = 7;
	localparam int CMD_GLYPH_BIT = 6;
	localparam int BUSY_BIT = 7;
	// synchronised pin vector layout: {rs, rw, e, db[7:0]}
	localparam int BUS_W = 11;
	localparam int BUS_RS = 10;
	localparam int BUS_RW = 9;
	localparam int BUS_E = 8;
	// =====================================================================
	// glyph layout
	localparam logic [2:0] CURSOR_ROW = 3'h7;
	localparam logic [3:0] USER_CODE_HI = 4'h0;
	localparam logic [7:0] ROM_NARROW_FIRST = 8'h10;
	localparam logic [7:0] ROM_NARROW_LAST = 8'hCF;
	localparam logic [7:0] ROM_TALL_FIRST = 8'hE0;
	localparam logic [3:0] ROWS_NARROW = 4'h7;
	localparam logic [3:0] ROWS_TALL = 4'hA;
	localparam logic [4:0] DOTS_DARK = 5'h00;
	localparam logic [4:0] DOTS_FULL = 5'h1F;

	typedef enum logic {MEM_TEXT, MEM_GLYPH} clcd_mem_e;
endpackage : clcd_pkg

// ==== logic/clcd_addr_mem.sv ====
// address pointer, text memory, user glyph memory and pixel fetch of the character display
// =====================================================================
// What this block does
// - address command loads pointer and picks memory
// - each data access steps pointer by one, except text pointer passes 27H<->40H and 67H<->00H
// - status read drives pointer on low lines
// - busy on top line, pointer below it
// - eighty-byte text memory, all locations usable
// - line to address map moved by the left shift count
// - shift rotates within two forty-address rings
// - glyph rom: 192 small, 32 tall patterns
// - 64-byte user glyph memory, fully usable
// - codes 00H-0FH show user glyphs
// - code bits 0-2 pick user pattern
// - pointer bits 0-2 pick row; on user codes only, row eight ORs cursor
// - data bits 0-4 are pixels, bit 4 left
// - code bits 4-7 zero select user; bit 3 ignored
// - one lights a pixel, zero leaves dark
// - direction bit one counts up, zero down
// - top bit set loads seven-bit text address
// - bits 7,6 = 0,1 load six-bit glyph address
`timescale 1ns/1ns
module clcd_addr_mem (
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	// host bus pins
	input wire logic I_RS,
	input wire logic I_RW,
	input wire logic I_E,
	input wire logic [7:0] I_DB,
	output logic [7:0] O_DB,
	output logic O_DB_OE_N,
	// controller state from the command decoder
	input wire logic I_BUSY,
	input wire logic I_STEP_UP,
	input wire logic [5:0] I_SHIFT_LEFT,
	// display scan
	input wire logic [1:0] I_SCAN_LINE,
	input wire logic [4:0] I_SCAN_COL,
	input wire logic [3:0] I_SCAN_ROW,
	input wire logic I_CURSOR_HERE,
	output logic [4:0] O_PIXELS,
	output clcd_pkg::clcd_mem_e O_MEM_SEL,
	output logic [6:0] O_POINTER
);
	import clcd_pkg::*;

	// =====================================================================
	// pin synchroniser: a bit is taken once stages two and three agree
	logic [BUS_W-1:0] sync1, sync2, sync3, bus, next_bus;
	logic e_prev;

	always_comb begin
		next_bus = ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & bus);
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			bus <= '0;
			e_prev <= 1'b0;
		end else begin
			sync1 <= {I_RS, I_RW, I_E, I_DB};
			sync2 <= sync1;
			sync3 <= sync2;
			bus <= next_bus;
			e_prev <= bus[BUS_E];
		end
	end

	logic e_fall, wr_cmd, wr_data, rd_data_done, rd_status;
	assign e_fall = e_prev & ~bus[BUS_E];
	assign wr_cmd = e_fall & ~bus[BUS_RS] & ~bus[BUS_RW];
	assign wr_data = e_fall & bus[BUS_RS] & ~bus[BUS_RW];
	assign rd_data_done = e_fall & bus[BUS_RS] & bus[BUS_RW];
	assign rd_status = bus[BUS_E] & ~bus[BUS_RS] & bus[BUS_RW];

	// =====================================================================
	// memories
	logic [7:0] text_mem [TEXT_DEPTH];
	logic [7:0] glyph_mem [GLYPH_DEPTH];
	logic [6:0] ptr, next_ptr;
	clcd_mem_e sel, next_sel;
	logic [6:0] text_idx;
	logic text_ok;

	// rings 00H-27H and 40H-67H map onto indices 0-39 and 40-79
	assign text_ok = ptr[5:0] <= RING0_LAST[5:0];
	assign text_idx = (ptr[6] ? RING1_INDEX : 7'h00) + {1'b0, ptr[5:0]};

	always_ff @(posedge I_CORE_CLK) begin
		if (wr_data && sel == MEM_TEXT && text_ok) begin
			text_mem[text_idx] <= bus[7:0];
		end
		if (wr_data && sel == MEM_GLYPH) begin
			glyph_mem[ptr[5:0]] <= bus[7:0];
		end
	end

	// =====================================================================
	// address pointer
	always_comb begin
		next_ptr = ptr;
		next_sel = sel;
		if (wr_cmd && bus[CMD_TEXT_BIT]) begin
			next_ptr = bus[6:0];
			next_sel = MEM_TEXT;
		end else if (wr_cmd && bus[CMD_GLYPH_BIT]) begin
			next_ptr = {1'b0, bus[5:0]};
			next_sel = MEM_GLYPH;
		end else if (wr_data || rd_data_done) begin
			if (sel == MEM_GLYPH) begin
				next_ptr = {1'b0, I_STEP_UP ? ptr[5:0] + 6'h01 : ptr[5:0] - 6'h01};
			end else if (I_STEP_UP) begin
				if (ptr == RING0_LAST) next_ptr = RING1_BASE;
				else if (ptr == RING1_LAST) next_ptr = RING0_BASE;
				else next_ptr = ptr + 7'h01;
			end else begin
				if (ptr == RING1_BASE) next_ptr = RING0_LAST;
				else if (ptr == RING0_BASE) next_ptr = RING1_LAST;
				else next_ptr = ptr - 7'h01;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			ptr <= PTR_RESET;
			sel <= MEM_TEXT;
		end else begin
			ptr <= next_ptr;
			sel <= next_sel;
		end
	end

	assign O_POINTER = ptr;
	assign O_MEM_SEL = sel;

	// =====================================================================
	// read path; data is fetched at the current pointer so a read always sees it
	logic [7:0] rd_byte, next_db;
	logic next_oe_n;

	always_comb begin
		if (sel == MEM_GLYPH) rd_byte = glyph_mem[ptr[5:0]];
		else if (text_ok) rd_byte = text_mem[text_idx];
		else rd_byte = 8'h00;
		next_db = rd_status ? {I_BUSY, ptr} : rd_byte;
		next_oe_n = ~(bus[BUS_E] & bus[BUS_RW]);
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			O_DB <= 8'h00;
			O_DB_OE_N <= 1'b1;
		end else begin
			O_DB <= next_db;
			O_DB_OE_N <= next_oe_n;
		end
	end

	// =====================================================================
	// pixel fetch for the scan position
	logic [6:0] ring_off, scan_off, scan_idx;
	logic [7:0] scan_code;
	logic [4:0] user_dots, next_pixels;
	logic user_sel;
	clcd_glyph_if glk ();

	clcd_glyph_rom u_rom (
		.lk(glk.rom)
	);

	always_comb begin
		// lines 3 and 4 continue the rings of lines 1 and 2
		ring_off = (I_SCAN_LINE[1] ? LOWER_HALF_OFFSET : 7'h00) + {2'h0, I_SCAN_COL}
			+ {1'b0, I_SHIFT_LEFT};
		scan_off = (ring_off >= RING_LEN_7) ? ring_off - RING_LEN_7 : ring_off;
		scan_idx = (I_SCAN_LINE[0] ? RING1_INDEX : 7'h00) + scan_off;
		scan_code = text_mem[scan_idx];
		user_sel = scan_code[7:4] == USER_CODE_HI;
		user_dots = glyph_mem[{scan_code[2:0], I_SCAN_ROW[2:0]}][4:0];
		if (I_SCAN_ROW[2:0] == CURSOR_ROW && I_CURSOR_HERE) begin
			user_dots = DOTS_FULL;
		end
		glk.code = scan_code;
		glk.row = I_SCAN_ROW;
		// a one bit lights the pixel, bit 4 is the leftmost
		next_pixels = user_sel ? user_dots : glk.dots;
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) O_PIXELS <= DOTS_DARK;
		else O_PIXELS <= next_pixels;
	end

	// =====================================================================
	// checks
	sequence s_text_cmd;
		wr_cmd && bus[CMD_TEXT_BIT];
	endsequence
	sequence s_glyph_cmd;
		wr_cmd && !bus[CMD_TEXT_BIT] && bus[CMD_GLYPH_BIT];
	endsequence
	sequence s_text_step_up;
		(wr_data || rd_data_done) && sel == MEM_TEXT && I_STEP_UP;
	endsequence

	a_text_load: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		s_text_cmd |=> ptr == $past(bus[6:0]) && sel == MEM_TEXT)
		else $error("text address command did not load pointer");
	a_glyph_load: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		s_glyph_cmd |=> ptr == {1'b0, $past(bus[5:0])} && sel == MEM_GLYPH)
		else $error("glyph address command did not load pointer");
	a_text_step_up: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		s_text_step_up and (ptr != RING0_LAST && ptr != RING1_LAST) |=> ptr == $past(ptr) + 7'h01)
		else $error("text pointer did not step up by one");
	a_text_gap_skip: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		s_text_step_up and ptr == RING0_LAST |=> ptr == RING1_BASE)
		else $error("text pointer did not jump from 27H to 40H");
	a_step_down: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(wr_data || rd_data_done) && !I_STEP_UP && sel == MEM_GLYPH
		|=> ptr[5:0] == $past(ptr[5:0]) - 6'h01 && !ptr[6])
		else $error("glyph pointer did not step down in six bits");
	a_status_word: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		rd_status |=> O_DB == {$past(I_BUSY), $past(ptr)} && !O_DB_OE_N)
		else $error("status read did not show busy and pointer");
	a_hold_idle: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!wr_cmd && !wr_data && !rd_data_done |=> $stable(ptr))
		else $error("pointer moved without an access");
	a_text_store: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		wr_data && sel == MEM_TEXT && text_ok |=> text_mem[$past(text_idx)] == $past(bus[7:0]))
		else $error("text write not stored");
	a_user_pixels: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		user_sel && !(I_CURSOR_HERE && I_SCAN_ROW[2:0] == CURSOR_ROW)
		|=> O_PIXELS == $past(glyph_mem[{scan_code[2:0], I_SCAN_ROW[2:0]}][4:0]))
		else $error("user code did not render user glyph row");
	a_read_drive: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		bus[BUS_E] && bus[BUS_RW] |=> !O_DB_OE_N)
		else $error("read did not enable the data drivers");
	a_release_bus: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!bus[BUS_E] |=> O_DB_OE_N)
		else $error("data drivers stayed on after enable fell");
endmodule : clcd_addr_mem

// ==== logic/clcd_glyph_rom.sv ====
// fixed glyph pattern table addressed by character code and pixel row
`timescale 1ns/1ns
module clcd_glyph_rom (
	// lookup
	clcd_glyph_if.rom lk
);
	import clcd_pkg::*;

	// =====================================================================
	// pattern table
	// the font contents are a stand-in; swap this function for the real font table
	function automatic logic [4:0] font_row(input logic [7:0] code, input logic [3:0] row);
		logic [4:0] pat;
		pat = code[4:0] ^ {row, 1'b0} ^ {2'h0, code[7:5]};
		return pat;
	endfunction : font_row

	always_comb begin
		lk.dots = DOTS_DARK;
		// 5x7 patterns, 192 codes
		if (lk.code >= ROM_NARROW_FIRST && lk.code <= ROM_NARROW_LAST && lk.row < ROWS_NARROW) begin
			lk.dots = font_row(lk.code, lk.row);
		end
		// 5x10 patterns, 32 codes
		else if (lk.code >= ROM_TALL_FIRST && lk.row < ROWS_TALL) begin
			lk.dots = font_row(lk.code, lk.row);
		end
	end
endmodule : clcd_glyph_rom

// ==== tb/clcd_addr_mem_tb.sv ====
// self-checking bench for the address pointer and glyph memory block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module clcd_addr_mem_tb;
	import clcd_pkg::*;
	logic clk;
	logic rst_n;
	logic rs;
	logic rw;
	logic e;
	logic [7:0] db;
	logic [7:0] o_db;
	logic oe_n;
	logic busy;
	logic up;
	logic [5:0] shl;
	logic [1:0] ln;
	logic [4:0] col;
	logic [3:0] row;
	logic cur;
	logic [4:0] pix;
	clcd_mem_e sel;
	logic [6:0] ptr;
	logic [7:0] rd;
	int n_errors = 0;
	int checks_done = 0;
	// {cmd, step up, pointer after one write, memory select, busy}
	localparam logic [17:0] PTR_ROWS [7] = '{{8'h80, 1'h1, 7'h01, 1'h0, 1'h0},
		{8'hA7, 1'h1, 7'h40, 1'h0, 1'h1}, {8'hE7, 1'h1, 7'h00, 1'h0, 1'h0},
		{8'hC0, 1'h0, 7'h27, 1'h0, 1'h1}, {8'h80, 1'h0, 7'h67, 1'h0, 1'h0},
		{8'h7F, 1'h1, 7'h00, 1'h1, 1'h1}, {8'h40, 1'h0, 7'h3F, 1'h1, 1'h0}};
	// {address cmd, code}; code 09H must show pattern one since code bit 3 is ignored
	// the last lands in the unmapped gap
	localparam logic [15:0] TXT_W [6] = '{16'h8009, 16'h81D5, 16'hD409, 16'hC009,
		16'h9409, 16'hB055};
	// {line, column, row, cursor, left shift, pixels}
	localparam logic [22:0] SCAN [12] = '{{2'h0, 5'h00, 4'h1, 1'h0, 6'h00, 5'h03},
		{2'h0, 5'h00, 4'h2, 1'h0, 6'h00, 5'h06}, {2'h0, 5'h00, 4'h0, 1'h0, 6'h00, 5'h00},
		{2'h0, 5'h00, 4'h7, 1'h0, 6'h00, 5'h15}, {2'h0, 5'h00, 4'h7, 1'h1, 6'h00, 5'h1F},
		{2'h2, 5'h00, 4'h1, 1'h0, 6'h00, 5'h03}, {2'h3, 5'h00, 4'h1, 1'h0, 6'h00, 5'h03},
		{2'h1, 5'h00, 4'h1, 1'h0, 6'h00, 5'h03}, {2'h2, 5'h13, 4'h1, 1'h0, 6'h01, 5'h03},
		{2'h3, 5'h13, 4'h1, 1'h0, 6'h01, 5'h03}, {2'h0, 5'h01, 4'h1, 1'h0, 6'h27, 5'h03},
		{2'h0, 5'h01, 4'h1, 1'h0, 6'h00, 5'h00}};

	clcd_addr_mem clcd_addr_mem_i (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_RS(rs),
		.I_RW(rw), .I_E(e), .I_DB(db), .O_DB(o_db), .O_DB_OE_N(oe_n), .I_BUSY(busy),
		.I_STEP_UP(up), .I_SHIFT_LEFT(shl), .I_SCAN_LINE(ln), .I_SCAN_COL(col),
		.I_SCAN_ROW(row), .I_CURSOR_HERE(cur), .O_PIXELS(pix), .O_MEM_SEL(sel),
		.O_POINTER(ptr));
	clcd_host_model clcd_host_model_i (.clk(clk), .rs(rs), .rw(rw), .e(e), .db(db),
		.rd_db(o_db));

	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	// =====================================================================
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		print_verdict;
	end

	// =====================================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		busy = 1'b0;
		up = 1'b1;
		shl = 6'h00;
		ln = 2'h0;
		col = 5'h00;
		row = 4'h0;
		cur = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		foreach (PTR_ROWS[i]) begin
			busy <= PTR_ROWS[i][0];
			up <= PTR_ROWS[i][9];
			clcd_host_model_i.xfer(1'b0, 1'b0, PTR_ROWS[i][17:10], rd);
			clcd_host_model_i.xfer(1'b1, 1'b0, 8'hD0, rd);
			clcd_host_model_i.xfer(1'b0, 1'b1, 8'h00, rd);
			`CHK("status", {PTR_ROWS[i][0], PTR_ROWS[i][8:2]}, rd)
			`CHK("mem_sel", PTR_ROWS[i][1], sel)
		end
		busy <= 1'b0;
		up <= 1'b1;
		// first row of pattern one, then one row per write
		clcd_host_model_i.xfer(1'b0, 1'b0, 8'h48, rd);
		for (int r = 0; r < 8; r++) clcd_host_model_i.xfer(1'b1, 1'b0, 8'hE0 + 8'(r * 3), rd);
		clcd_host_model_i.xfer(1'b0, 1'b0, 8'h48, rd);
		for (int r = 0; r < 8; r++) begin
			clcd_host_model_i.xfer(1'b1, 1'b1, 8'h00, rd);
			`CHK("glyph_byte", 8'hE0 + 8'(r * 3), rd)
		end
		clcd_host_model_i.xfer(1'b0, 1'b1, 8'h00, rd);
		`CHK("ptr_after_reads", 8'h10, rd)
		foreach (TXT_W[i]) begin
			clcd_host_model_i.xfer(1'b0, 1'b0, TXT_W[i][15:8], rd);
			clcd_host_model_i.xfer(1'b1, 1'b0, TXT_W[i][7:0], rd);
		end
		clcd_host_model_i.xfer(1'b0, 1'b0, 8'hB0, rd);
		clcd_host_model_i.xfer(1'b1, 1'b1, 8'h00, rd);
		`CHK("gap_read", 8'h00, rd)
		clcd_host_model_i.xfer(1'b0, 1'b0, 8'h80, rd);
		clcd_host_model_i.xfer(1'b1, 1'b1, 8'h00, rd);
		`CHK("text_read", 8'h09, rd)
		foreach (SCAN[i]) begin
			@(posedge clk);
			ln <= SCAN[i][22:21];
			col <= SCAN[i][20:16];
			row <= SCAN[i][15:12];
			cur <= SCAN[i][11];
			shl <= SCAN[i][10:5];
			repeat (2) @(posedge clk);
			#1;
			`CHK("pixels", SCAN[i][4:0], pix)
		end
		// rom path: the font is a stand-in, so only lit or dark is known
		clcd_host_model_i.xfer(1'b0, 1'b0, 8'h82, rd);
		clcd_host_model_i.xfer(1'b1, 1'b0, 8'h41, rd);
		clcd_host_model_i.xfer(1'b1, 1'b0, 8'hE8, rd);
		@(posedge clk);
		col <= 5'h02;
		row <= 4'h0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("rom_narrow_lit", 1'b1, pix != 5'h00)
		@(posedge clk);
		row <= 4'h8;
		repeat (2) @(posedge clk);
		#1;
		`CHK("rom_narrow_row8", 5'h00, pix)
		@(posedge clk);
		col <= 5'h03;
		row <= 4'h9;
		repeat (2) @(posedge clk);
		#1;
		`CHK("rom_tall_lit", 1'b1, pix != 5'h00)
		// reset in mid-run
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		#1;
		`CHK("ptr_rst", 7'h00, ptr)
		`CHK("sel_rst", MEM_TEXT, sel)
		`CHK("oe_rst", 1'b1, oe_n)
		`CHK("pix_rst", 5'h00, pix)
		@(posedge clk);
		rst_n <= 1'b1;
		// first access right after release must see a cleared pointer
		clcd_host_model_i.xfer(1'b0, 1'b1, 8'h00, rd);
		`CHK("status_after_rst", 8'h00, rd)
		print_verdict;
	end
endmodule : clcd_addr_mem_tb

// ==== tb/clcd_host_model.sv ====
// host processor model driving the parallel pin bus of the display block
`timescale 1ns/1ns
module clcd_host_model (
	// clock
	input wire logic clk,
	// pins toward the block
	output logic rs,
	output logic rw,
	output logic e,
	output logic [7:0] db,
	// data driven back by the block
	input wire logic [7:0] rd_db
);
	// =====================================================================
	// one bus cycle; E phases of eight clocks so the synchronisers see them
	task automatic xfer(input logic sel, input logic rd, input logic [7:0] wd,
		output logic [7:0] rdat);
		@(posedge clk);
		rs <= sel;
		rw <= rd;
		// released lines do not keep the last value
		db <= rd ? ~db : wd;
		repeat (2) @(posedge clk);
		e <= 1'b1;
		repeat (8) @(posedge clk);
		rdat = rd_db;
		e <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : xfer

	initial begin
		rs = 1'b0;
		rw = 1'b0;
		e = 1'b0;
		db = 8'h00;
	end
endmodule : clcd_host_model
